// ==== rtl/dvsw_pkg.sv ====
// Package for the converter setting-select and watchdog-restore control block.
// Assumes a single 25 MHz clock and a simple byte-wide register port.
package dvsw_pkg;

  // Register byte addresses of the four setting-select registers
  localparam logic [7:0] CH1_SETTING_SELECT_ADDR = 8'h52;
  localparam logic [7:0] CH2_SETTING_SELECT_ADDR = 8'h6C;
  localparam logic [7:0] CH3_SETTING_SELECT_ADDR = 8'h86;
  localparam logic [7:0] CH4_SETTING_SELECT_ADDR = 8'hA0;

  // Field layout of a setting-select register
  localparam int SEL_MODE_LSB = 0;
  localparam int SEL_MODE_MSB = 1;
  localparam int SEL_POL_BIT = 2;
  localparam int SEL_USED_MSB = 2;

  // Mode codes of the two-bit selection field
  localparam logic [1:0] SEL_MODE_FIRST = 2'h0;
  localparam logic [1:0] SEL_MODE_PIN = 2'h2;

  // Reset value of a setting-select register
  localparam logic [7:0] SETTING_SELECT_RESET = 8'h00;

  // Channel count
  localparam int NUM_CH = 4;

  // Watchdog-restore debounce: least time, clock rate and derived cycle count
  localparam int WDOG_DEBOUNCE_US = 100;
  localparam int CLK_FREQ_MHZ = 25;
  localparam int WDOG_DEBOUNCE_CYCLES = WDOG_DEBOUNCE_US * CLK_FREQ_MHZ;
  localparam int WDOG_CNT_W = 12;

  // Debounce progress states, Gray coded from IDLE through COUNT to HELD
  typedef enum logic [1:0] {
    DVSW_WD_IDLE = 2'b00,
    DVSW_WD_COUNT = 2'b01,
    DVSW_WD_HELD = 2'b11
  } dvsw_wd_state_t;

endpackage

// ==== rtl/dvsw_ctrl.sv ====
// Setting-select, watchdog-restore and master-enable control for four channels.
// Assumes pins are asynchronous to clk and a byte-wide register port from the
// serial interface logic (address, write strobe, write data, read data).
//
// Overview of operation
// RULE1: Field code 10 hands the setting choice to the channel's select pin.
// RULE2: Bit 2 sets the polarity used to read the channel's select pin.
// RULE3: Documented polarity: pin high picks first setting, pin low picks second.
// RULE4: Field resets to 00; first setting used and select pin ignored.
// RULE5: Selection registers sit at ch1_setting_select, ch2_setting_select, ch3_setting_select, ch4_setting_select, same layout.
// RULE6: Held-low restore pin returns voltage and scaling registers to defaults; code clears only the select registers and raises restore_defaults.
// RULE7: Restore pin must stay low at least 100 us before it acts.
// RULE8: Enable pin high runs converters; low forces shutdown.
// RULE9: Select, restore and enable pins pass two flip-flops before use.
`timescale 1ns/10ps
`default_nettype none

module dvsw_ctrl
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ch1_setting_select_pin,
  input wire logic ch2_setting_select_pin,
  input wire logic ch3_setting_select_pin,
  input wire logic ch4_setting_select_pin,
  input wire logic watchdog_restore_pin,
  input wire logic enable_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [3:0] use_second_setting,
  output logic restore_defaults,
  output logic converters_run
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0][7:0] sel;
    logic [5:0] sync1;
    logic [5:0] sync2;
    dvsw_pkg::dvsw_wd_state_t wd_state;
    logic [dvsw_pkg::WDOG_CNT_W-1:0] wd_cnt;
    logic [7:0] rdata;
    logic [3:0] second;
    logic restore;
    logic run;
  } dvsw_state_t;

  dvsw_state_t state_reg;
  dvsw_state_t state_next;

  // Address decode: channel index of a selection register, or none
  function automatic logic [2:0] dvsw_decode(input logic [7:0] addr);
    logic [2:0] hit;
    hit = 3'h4;
    unique case (addr)
      dvsw_pkg::CH1_SETTING_SELECT_ADDR: hit = 3'h0;
      dvsw_pkg::CH2_SETTING_SELECT_ADDR: hit = 3'h1;
      dvsw_pkg::CH3_SETTING_SELECT_ADDR: hit = 3'h2;
      dvsw_pkg::CH4_SETTING_SELECT_ADDR: hit = 3'h3;
      default: hit = 3'h4;
    endcase
    return hit;
  endfunction

  // Setting choice of one channel from its register and synchronised pin
  function automatic logic dvsw_pick_second(input logic [7:0] sel, input logic pin);
    logic second;
    second = 1'b0;
    if (sel[dvsw_pkg::SEL_MODE_MSB:dvsw_pkg::SEL_MODE_LSB] == dvsw_pkg::SEL_MODE_PIN) // RULE1
    begin
      // Polarity clear: high pin gives the first setting, low the second
      second = ~(pin ^ sel[dvsw_pkg::SEL_POL_BIT]); // RULE2 RULE3
    end
    else
    begin
      second = 1'b0; // RULE4
    end
    return second;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    logic [2:0] wr_hit;
    logic [2:0] rd_hit;
    logic [3:0] pins;
    logic wd_low;
    wr_hit = dvsw_decode(reg_addr);
    rd_hit = dvsw_decode(reg_addr);
    pins = '0;
    wd_low = 1'b0;
    state_next = state_reg;

    // Two-stage synchronisers; only sync2 feeds logic
    state_next.sync1 = {enable_pin, watchdog_restore_pin, ch4_setting_select_pin,
                        ch3_setting_select_pin, ch2_setting_select_pin,
                        ch1_setting_select_pin}; // RULE9
    state_next.sync2 = state_reg.sync1; // RULE9
    pins = state_reg.sync2[3:0];
    wd_low = ~state_reg.sync2[4];

    // Register writes; unused bits are kept at zero
    if (reg_wr && (wr_hit != 3'h4)) // RULE5
    begin
      state_next.sel[wr_hit[1:0]] = {5'h00, reg_wdata[dvsw_pkg::SEL_USED_MSB:0]};
    end

    // Register reads; unmapped addresses read zero
    if (rd_hit != 3'h4) // RULE5
    begin
      state_next.rdata = state_reg.sel[rd_hit[1:0]];
    end
    else
    begin
      state_next.rdata = 8'h00;
    end

    // Watchdog-restore debounce, counted on the synchronised level
    state_next.restore = 1'b0;
    unique case (state_reg.wd_state)
      dvsw_pkg::DVSW_WD_IDLE:
      begin
        state_next.wd_cnt = '0;
        if (wd_low)
        begin
          state_next.wd_state = dvsw_pkg::DVSW_WD_COUNT;
        end
      end
      dvsw_pkg::DVSW_WD_COUNT:
      begin
        if (!wd_low)
        begin
          state_next.wd_state = dvsw_pkg::DVSW_WD_IDLE;
        end
        else if (state_reg.wd_cnt ==
                 dvsw_pkg::WDOG_CNT_W'(dvsw_pkg::WDOG_DEBOUNCE_CYCLES - 1)) // RULE7
        begin
          state_next.wd_state = dvsw_pkg::DVSW_WD_HELD;
          state_next.restore = 1'b1; // RULE6
        end
        else
        begin
          state_next.wd_cnt = state_reg.wd_cnt + 1'b1;
        end
      end
      dvsw_pkg::DVSW_WD_HELD:
      begin
        // Defaults held while the pin stays low
        state_next.restore = wd_low; // RULE6
        if (!wd_low)
        begin
          state_next.wd_state = dvsw_pkg::DVSW_WD_IDLE;
        end
      end
      default:
      begin
        state_next.wd_state = dvsw_pkg::DVSW_WD_IDLE;
      end
    endcase

    // Restore pulls the four setting-select registers back to factory values too
    if (state_next.restore) // RULE6
    begin
      for (int i = 0; i < dvsw_pkg::NUM_CH; i++)
      begin
        state_next.sel[i] = dvsw_pkg::SETTING_SELECT_RESET;
      end
    end

    // Per-channel setting choice
    for (int i = 0; i < dvsw_pkg::NUM_CH; i++)
    begin
      state_next.second[i] = dvsw_pick_second(state_reg.sel[i], pins[i]);
    end

    // Master enable
    state_next.run = state_reg.sync2[5]; // RULE8
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < dvsw_pkg::NUM_CH; i++)
      begin
        state_reg.sel[i] <= dvsw_pkg::SETTING_SELECT_RESET; // RULE4
      end
      state_reg.sync1 <= 6'h00;
      state_reg.sync2 <= 6'h00;
      state_reg.wd_state <= dvsw_pkg::DVSW_WD_IDLE;
      state_reg.wd_cnt <= '0;
      state_reg.rdata <= 8'h00;
      state_reg.second <= 4'h0;
      state_reg.restore <= 1'b0;
      state_reg.run <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign reg_rdata = state_reg.rdata;
  assign use_second_setting = state_reg.second;
  assign restore_defaults = state_reg.restore;
  assign converters_run = state_reg.run;

endmodule

`default_nettype wire

// ==== verif/dvsw_ctrl_props.sv ====
// Checker for the select, restore and enable control block.
// Sees only top-level ports; bound to every dvsw_ctrl instance below.
`timescale 1ns/10ps
`default_nettype none
module dvsw_ctrl_props
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic watchdog_restore_pin,
  input wire logic enable_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] use_second_setting,
  input wire logic restore_defaults,
  input wire logic converters_run
);
  logic [11:0] low_cnt_reg;
  logic mapped;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Address decode of the four select registers
  assign mapped = reg_addr inside {8'h52, 8'h6C, 8'h86, 8'hA0};
  // Consecutive low samples of the restore pin, saturating
  always_ff @(posedge clk)
    low_cnt_reg <= (!nrst || watchdog_restore_pin) ? 12'h000 : low_cnt_reg + 12'(~&low_cnt_reg);
  ////////////////////////////////////////////////////////////////////////////////
  property p_run_on; enable_pin [*3] |=> converters_run; endproperty
  a_run_on: assert property (p_run_on) else $error("run missing");
  property p_run_off; !enable_pin [*3] |=> !converters_run; endproperty
  a_run_off: assert property (p_run_off) else $error("shutdown missing");
  property p_rst_early; $rose(restore_defaults) |-> low_cnt_reg >= 12'h9C4; endproperty
  a_rst_early: assert property (p_rst_early) else $error("restore too early");
  property p_rst_late; low_cnt_reg >= 12'h9D8 |-> restore_defaults; endproperty
  a_rst_late: assert property (p_rst_late) else $error("restore missing");
  property p_rst_end; watchdog_restore_pin [*3] |=> !restore_defaults; endproperty
  a_rst_end: assert property (p_rst_end) else $error("restore stuck");
  property p_rst_sel; restore_defaults [*3] |-> use_second_setting == 4'h0; endproperty
  a_rst_sel: assert property (p_rst_sel) else $error("select kept");
  property p_unmap; !mapped |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_wr_rd;
    (reg_wr && mapped) ##1 (reg_addr == $past(reg_addr) && !reg_wr)
      |=> restore_defaults || reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)};
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback wrong");
endmodule
bind dvsw_ctrl dvsw_ctrl_props dvsw_ctrl_props_inst (.*);
`default_nettype wire

// ==== verif/dvsw_host_model.sv ====
// Host model: launches select, restore and enable pin levels.
// Assumes the bench sets wanted levels; pins change just after an edge.
`timescale 1ns/10ps
`default_nettype none
module dvsw_host_model
(
  input wire logic clk,
  input wire logic [3:0] sel_req,
  input wire logic wd_req,
  input wire logic en_req,
  output logic [3:0] sel_pin = 4'h0,
  output logic wd_pin = 1'b1,
  output logic en_pin = 1'b0
);
  // Pins follow requests one edge later; restore held low while asked
  always @(posedge clk)
  begin
    sel_pin <= sel_req;
    wd_pin <= wd_req;
    en_pin <= en_req;
  end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Testbench: register port tasks plus host model driving the pins.
// Assumes dvsw_ctrl, its checker and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] sel_req = 4'h5;
  logic wd_req = 1'b1;
  logic en_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] sel_pin, use_second_setting, exp;
  logic wd_pin, en_pin, restore_defaults, converters_run;
  logic [7:0] reg_rdata;
  logic [7:0] addrs [4] = '{8'h52, 8'h6C, 8'h86, 8'hA0};
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  dvsw_host_model dvsw_host_model_inst (.clk(clk), .sel_req(sel_req), .wd_req(wd_req),
    .en_req(en_req), .sel_pin(sel_pin), .wd_pin(wd_pin), .en_pin(en_pin));
  dvsw_ctrl dvsw_ctrl_inst (.clk(clk), .nrst(nrst), .ch1_setting_select_pin(sel_pin[0]),
    .ch2_setting_select_pin(sel_pin[1]), .ch3_setting_select_pin(sel_pin[2]),
    .ch4_setting_select_pin(sel_pin[3]), .watchdog_restore_pin(wd_pin),
    .enable_pin(en_pin), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .use_second_setting(use_second_setting),
    .restore_defaults(restore_defaults), .converters_run(converters_run));
  // Clock and cycle ceiling
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 9000)
    begin
      mismatches++;
      $display("mismatch at %0t: run too long", $time);
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, wait, register write and read tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    reg_addr <= a;
    wt(1);
    chk(reg_rdata, want);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset, mode and polarity sweep, restore pulses, enable
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(addrs[i], 8'h00);
    rd(8'h53, 8'h00);
    $display("test reset done");
    en_req <= 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      for (int i = 0; i < 4; i++)
        wr(addrs[i], 8'hF8 | 8'(m));
      wt(6);
      exp = (m[1:0] != 2'h2) ? 4'h0 : (m[2] ? 4'h5 : 4'hA);
      chk({4'h0, use_second_setting}, {4'h0, exp});
      rd(addrs[m[1:0]], 8'(m));
    end
    chk({7'h00, converters_run}, 8'h01);
    $display("test select done");
    wr(addrs[1], 8'h02);
    @(posedge clk) wd_req <= 1'b0;
    wt(2000);
    chk({7'h00, restore_defaults}, 8'h00);
    @(posedge clk) wd_req <= 1'b1;
    wt(6);
    rd(addrs[1], 8'h02);
    @(posedge clk) wd_req <= 1'b0;
    wt(2600);
    chk({7'h00, restore_defaults}, 8'h01);
    chk({4'h0, use_second_setting}, 8'h00);
    rd(addrs[1], 8'h00);
    @(posedge clk) wd_req <= 1'b1;
    @(posedge clk) en_req <= 1'b0;
    wt(6);
    chk({6'h00, restore_defaults, converters_run}, 8'h00);
    $display("test restore done");
    close_out();
  end
endmodule
`default_nettype wire
